// [core/pde_map.vh]
// Register offsets, field positions and reset values of the port D/E pin block
`ifndef PDE_MAP_VH
`define PDE_MAP_VH
// ==========================================================================
// Word offsets (byte address = 4 * offset)
`define PDE_OFS_D_PIN      3'h0
`define PDE_OFS_D_LATCH    3'h1
`define PDE_OFS_D_DIR      3'h2
`define PDE_OFS_E_PIN      3'h3
`define PDE_OFS_E_LATCH    3'h4
`define PDE_OFS_E_DIR      3'h5
`define PDE_OFS_ANALOG     3'h6
`define PDE_OFS_PWM_CTRL   3'h7
// ==========================================================================
// Fields of port_e_direction_and_host_ctrl
`define PDE_E_IBF_BIT      7
`define PDE_E_OBF_BIT      6
`define PDE_E_IBOV_BIT     5
`define PDE_E_MODE_BIT     4
// Fields of the pwm control register
`define PDE_PWM_EN_B_BIT   0
`define PDE_PWM_EN_C_BIT   1
`define PDE_PWM_EN_D_BIT   2
`define PDE_PWM_MULTI_BIT  3
`define PDE_PWM_TRI_BIT    4
// ==========================================================================
// Reset values
`define PDE_RST_D_DIR      8'hFF
`define PDE_RST_E_DIR      3'h7
`define PDE_RST_ANALOG     3'h7
`define PDE_RST_LATCH      8'h00
`define PDE_RST_ERR        32'h00000000
`endif

// [core/pde_port_pins.v]
// Port D and port E pin control with an Avalon-MM register slave
// How it works
// [RULE1] Host port mode drives the latch onto port D for host reads, ignoring direction.
// [RULE2] Host port mode captures port D pins as host write data regardless of direction.
// [RULE3] Enabled PWM on D5..D7 with direction 0 overrides port and host data.
// [RULE4] PWM pins can float during a shutdown event when tri-state is configured.
// [RULE5] Direction 1 turns the driver off; direction 0 drives the latch.
// [RULE6] Latch registers read back the latched value, not the pin.
// [RULE7] A port E pin selected as analog reads back as zero.
// [RULE8] Port E direction still drives analog pins; software keeps them inputs.
// [RULE9] After reset port E bits 2..0 are analog inputs.
// [RULE10] Upper four port E direction bits hold host port control and status.
// [RULE11] Fourth port E pin is input only; digital when master clear is off.
// [RULE12] At reset that pin is a digital input only when master clear is off.
// [RULE13] Large package: port E is four bits, three bidirectional.
// [RULE14] Small package: port E is only the input-only pin, present without master clear.
// [RULE15] Bit 4 of port E control selects host port mode when one.
// [RULE16] Dual or quad PWM output disables host port functions of port D.
// [RULE17] Port data reads return pin levels; writes update the latch.
`default_nettype none
`include "pde_map.vh"

module pde_port_pins #(
  parameter LARGE_PKG = 1
) (
  input wire clock,
  input wire srst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  input wire [7:0] port_d_in,
  output reg [7:0] port_d_out,
  output reg [7:0] port_d_oe,
  input wire [3:0] port_e_in,
  output reg [2:0] port_e_out,
  output reg [2:0] port_e_oe,
  input wire master_clear_enable_cfg,
  output reg master_clear_input,
  input wire pwm_out_b,
  input wire pwm_out_c,
  input wire pwm_out_d,
  input wire pwm_shutdown,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire host_cs_n,
  output reg host_port_mode_sel,
  output reg [7:0] host_write_data,
  output reg host_write_strobe
);

  // ==========================================================================
  // Register state
  reg [7:0] d_latch_ff;
  reg [7:0] d_dir_ff;
  reg [2:0] e_latch_ff;
  reg [2:0] e_dir_ff;
  reg [2:0] analog_ff;
  reg mode_ff;
  reg ibf_ff;
  reg obf_ff;
  reg ibov_ff;
  reg [4:0] pwm_ctrl_ff;
  reg [7:0] d_pin_ff;
  reg [3:0] e_pin_ff;
  reg wr_prev_ff;
  reg rd_prev_ff;
  reg busy_ff;
  reg master_clear_input_cap_ff;
  reg master_clear_input_seen_ff;

  wire sel_large;
  wire host_active;
  wire [2:0] pwm_en;
  wire [2:0] pwm_val;
  wire [7:0] pin_level_in;
  wire host_wr_now;
  wire host_rd_now;
  wire host_wr_end;
  wire host_rd_end;
  wire acc;
  wire wr_acc;
  wire [2:0] word;
  wire bad_addr;

  assign sel_large = (LARGE_PKG != 0);
  // Multi-output PWM steals the host port pins
  assign host_active = mode_ff & ~pwm_ctrl_ff[`PDE_PWM_MULTI_BIT] & sel_large; // [RULE16]
  assign pwm_en = pwm_ctrl_ff[`PDE_PWM_EN_D_BIT:`PDE_PWM_EN_B_BIT] & ~d_dir_ff[7:5]; // [RULE3]
  assign pwm_val = {pwm_out_d, pwm_out_c, pwm_out_b};
  assign pin_level_in = port_d_in;
  assign host_wr_now = host_active & ~host_cs_n & ~host_wr_n;
  assign host_rd_now = host_active & ~host_cs_n & ~host_rd_n;
  assign host_wr_end = wr_prev_ff & ~host_wr_now;
  assign host_rd_end = rd_prev_ff & ~host_rd_now;
  assign acc = (avs_read | avs_write) & ~busy_ff;
  assign wr_acc = avs_write & ~busy_ff & avs_byteenable[0];
  assign word = avs_address[4:2];
  assign bad_addr = (avs_address[1:0] != 2'h0);

  // ==========================================================================
  // Pin drivers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_d_pin
      always @(posedge clock)
      begin
        if (srst)
        begin
          port_d_out[gi] <= 1'b0;
          port_d_oe[gi] <= 1'b0;
        end
        else if (gi >= 5 && pwm_en[(gi >= 5) ? gi - 5 : 0])
        begin
          port_d_out[gi] <= pwm_val[(gi >= 5) ? gi - 5 : 0]; // [RULE3]
          // Shutdown may float the pin instead of driving it
          port_d_oe[gi] <= ~(pwm_shutdown & pwm_ctrl_ff[`PDE_PWM_TRI_BIT]); // [RULE4]
        end
        else if (host_active)
        begin
          port_d_out[gi] <= d_latch_ff[gi]; // [RULE1]
          port_d_oe[gi] <= host_rd_now; // [RULE1]
        end
        else
        begin
          port_d_out[gi] <= d_latch_ff[gi]; // [RULE5]
          port_d_oe[gi] <= ~d_dir_ff[gi]; // [RULE5]
        end
      end
    end
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_e_pin
      always @(posedge clock)
      begin
        if (srst)
        begin
          port_e_out[gi] <= 1'b0;
          port_e_oe[gi] <= 1'b0;
        end
        else
        begin
          // Analog select does not gate the driver
          port_e_out[gi] <= e_latch_ff[gi]; // [RULE8]
          port_e_oe[gi] <= ~e_dir_ff[gi] & sel_large & ~host_active; // [RULE13] [RULE8]
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Pin sampling and host port capture
  always @(posedge clock)
  begin
    if (srst)
    begin
      d_pin_ff <= 8'h00;
      e_pin_ff <= 4'h0;
      wr_prev_ff <= 1'b0;
      rd_prev_ff <= 1'b0;
      host_write_data <= 8'h00;
      host_write_strobe <= 1'b0;
      master_clear_input <= 1'b0;
    end
    else
    begin
      d_pin_ff <= pin_level_in; // [RULE17]
      e_pin_ff[2:0] <= port_e_in[2:0] & ~analog_ff & {3{sel_large}}; // [RULE7] [RULE14]
      // Pin exists as data only with master clear disabled
      e_pin_ff[3] <= port_e_in[3] & ~master_clear_enable_cfg; // [RULE11] [RULE12]
      master_clear_input <= master_clear_enable_cfg & ~port_e_in[3]; // [RULE11]
      wr_prev_ff <= host_wr_now;
      rd_prev_ff <= host_rd_now;
      host_write_strobe <= host_wr_end;
      if (host_wr_now)
        host_write_data <= port_d_in; // [RULE2]
    end
  end

  // ==========================================================================
  // Register slave: one wait cycle, then answer
  always @(posedge clock)
  begin
    if (srst)
    begin
      busy_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
      d_latch_ff <= `PDE_RST_LATCH;
      d_dir_ff <= `PDE_RST_D_DIR;
      e_latch_ff <= 3'h0;
      e_dir_ff <= `PDE_RST_E_DIR;
      analog_ff <= `PDE_RST_ANALOG; // [RULE9]
      mode_ff <= 1'b0;
      ibf_ff <= 1'b0;
      obf_ff <= 1'b0;
      ibov_ff <= 1'b0;
      pwm_ctrl_ff <= 5'h00;
      host_port_mode_sel <= 1'b0;
    end
    else
    begin
      busy_ff <= acc;
      avs_waitrequest <= ~acc;
      host_port_mode_sel <= host_active;
      if (acc)
      begin
        avs_response <= bad_addr ? 2'h2 : 2'h0;
        avs_readdata <= 32'h00000000;
        if (avs_read && !bad_addr)
        begin
          case (word)
            `PDE_OFS_D_PIN: avs_readdata[7:0] <= d_pin_ff; // [RULE17]
            `PDE_OFS_D_LATCH: avs_readdata[7:0] <= d_latch_ff; // [RULE6]
            `PDE_OFS_D_DIR: avs_readdata[7:0] <= d_dir_ff;
            `PDE_OFS_E_PIN: avs_readdata[3:0] <= e_pin_ff; // [RULE7]
            `PDE_OFS_E_LATCH: avs_readdata[2:0] <= e_latch_ff; // [RULE6]
            `PDE_OFS_E_DIR: avs_readdata[7:0] <= {ibf_ff, obf_ff, ibov_ff, mode_ff,
                                                 1'b0, e_dir_ff}; // [RULE10]
            `PDE_OFS_ANALOG: avs_readdata[2:0] <= analog_ff;
            `PDE_OFS_PWM_CTRL: avs_readdata[4:0] <= pwm_ctrl_ff;
            default: avs_readdata <= 32'h00000000;
          endcase
        end
      end
      // Pin and latch offsets both write the latch
      if (wr_acc && !bad_addr && (word == `PDE_OFS_D_PIN || word == `PDE_OFS_D_LATCH))
        d_latch_ff <= avs_writedata[7:0]; // [RULE17] [RULE6]
      if (wr_acc && !bad_addr && word == `PDE_OFS_D_DIR)
        d_dir_ff <= avs_writedata[7:0]; // [RULE5]
      if (wr_acc && !bad_addr && (word == `PDE_OFS_E_PIN || word == `PDE_OFS_E_LATCH))
        e_latch_ff <= avs_writedata[2:0]; // [RULE17]
      if (wr_acc && !bad_addr && word == `PDE_OFS_E_DIR)
      begin
        e_dir_ff <= avs_writedata[2:0];
        mode_ff <= avs_writedata[`PDE_E_MODE_BIT]; // [RULE15]
      end
      if (wr_acc && !bad_addr && word == `PDE_OFS_ANALOG)
        analog_ff <= avs_writedata[2:0];
      if (wr_acc && !bad_addr && word == `PDE_OFS_PWM_CTRL)
        pwm_ctrl_ff <= avs_writedata[4:0];
      // Input buffer status: host write sets, cpu read of port D pin register clears
      if (host_wr_end)
        ibf_ff <= 1'b1; // [RULE10]
      else if (acc && avs_read && !bad_addr && word == `PDE_OFS_D_PIN)
        ibf_ff <= 1'b0;
      // Overflow set wins over software clear in the same cycle
      if (host_wr_end && ibf_ff)
        ibov_ff <= 1'b1; // [RULE10]
      else if (wr_acc && !bad_addr && word == `PDE_OFS_E_DIR && !avs_writedata[`PDE_E_IBOV_BIT])
        ibov_ff <= 1'b0;
      // Output full set by cpu latch write, cleared by host read
      if (wr_acc && !bad_addr && host_active &&
          (word == `PDE_OFS_D_PIN || word == `PDE_OFS_D_LATCH))
        obf_ff <= 1'b1; // [RULE10]
      else if (host_rd_end)
        obf_ff <= 1'b0;
    end
  end

endmodule // pde_port_pins
`default_nettype wire

// [verif/pde_chk.sv]
// Port-level checker for the port D/E pin block
`default_nettype none
module pde_chk #(
  parameter LARGE_PKG = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [7:0] port_d_in,
  input wire logic [7:0] port_d_oe,
  input wire logic [3:0] port_e_in,
  input wire logic [2:0] port_e_oe,
  input wire logic master_clear_enable_cfg,
  input wire logic master_clear_input,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_cs_n,
  input wire logic host_port_mode_sel,
  input wire logic [7:0] host_write_data,
  input wire logic host_write_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Mode settled long enough for the latched strobes to count
  sequence s_mode_held;
    host_port_mode_sel [*3];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> avs_waitrequest &&
    port_d_oe == 8'h00 && port_e_oe == 3'h0) else $error("outputs not quiet in reset");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_answer_one: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_misalign_err: assert property ($rose(avs_read || avs_write) &&
    avs_address[1:0] != 2'h0 |=> avs_response == 2'h2) else $error("misaligned not refused");
  a_host_read_drv: assert property (s_mode_held |->
    port_d_oe[4:0] == {5{$past(!host_cs_n && !host_rd_n)}}) else $error("host read drive");
  a_host_wr_cap: assert property (s_mode_held ##0 $past(!host_cs_n && !host_wr_n) |->
    host_write_data == $past(port_d_in)) else $error("host write data not captured");
  a_strobe_pulse: assert property (host_write_strobe |=> !host_write_strobe)
    else $error("write strobe longer than one cycle");
  a_master_clear_input_follow: assert property (!$past(srst) |-> master_clear_input ==
    $past(master_clear_enable_cfg && !port_e_in[3])) else $error("master clear mismatch");
  a_small_pkg: assert property (LARGE_PKG == 0 |-> port_e_oe == 3'h0)
    else $error("small package drives port E");
endmodule // pde_chk
bind pde_port_pins pde_chk #(.LARGE_PKG(LARGE_PKG)) u_pde_chk (.*);
`default_nettype wire

// [verif/pde_pin_model.sv]
// External circuitry on the port D pins
`default_nettype none
module pde_pin_model (
  input wire logic clock,
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_ff = 8'h00;
  // Floating pins toggle every cycle so a stale level never passes
  always_comb
    for (int i = 0; i < 8; i++)
      pin[i] = drv_oe[i] ? drv_out[i] : (ext_en[i] ? ext_val[i] : ~last_ff[i]);
  always @(posedge clock)
    last_ff <= pin;
endmodule // pde_pin_model
`default_nettype wire

// [verif/testbench.sv]
// Register-level testbench for the port D/E pin block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF, port_e_in = 4'h0;
  logic [1:0] avs_response, resp;
  logic [7:0] port_d_in, port_d_out, port_d_oe, host_write_data, rdat;
  logic [7:0] ext_val = 8'h3C, ext_en = 8'hFF;
  logic [2:0] port_e_out, port_e_oe;
  logic master_clear_enable_cfg = 1'b0, master_clear_input, host_write_strobe;
  logic pwm_out_b = 1'b0, pwm_out_c = 1'b0, pwm_out_d = 1'b0, pwm_shutdown = 1'b0;
  logic host_rd_n = 1'b1, host_wr_n = 1'b1, host_cs_n = 1'b1, host_port_mode_sel;
  int failures = 0, cmp_count = 0;
  pde_port_pins #(.LARGE_PKG(1)) u_pde_port_pins (.*);
  pde_pin_model u_pde_pin_model (.clock(clock), .drv_out(port_d_out), .drv_oe(port_d_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin(port_d_in));
  initial
    forever #10 clock = ~clock;
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata[7:0];
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      $display("[FAIL] %0t no answer from register slave", $time);
    end
  endtask
  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    acc(1'b1, {o, 2'h0}, d);
  endtask
  task automatic rd(input logic [2:0] o, input logic [7:0] exp);
    acc(1'b0, {o, 2'h0}, 8'h00);
    chk(rdat, exp);
  endtask
  task automatic hst(input logic r_n, input logic w_n);
    @(posedge clock);
    host_cs_n <= r_n & w_n;
    host_rd_n <= r_n;
    host_wr_n <= w_n;
    wt(3);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    wt(16);
    srst <= 1'b0;
    rd(3'h2, 8'hFF);
    rd(3'h5, 8'h07);
    rd(3'h6, 8'h07);
    rd(3'h1, 8'h00);
    $display("test reset done");
    wr(3'h1, 8'hA5);
    wr(3'h2, 8'h00);
    wt(3);
    rd(3'h0, 8'hA5);
    wr(3'h2, 8'hFF);
    wt(3);
    rd(3'h0, 8'h3C);
    rd(3'h1, 8'hA5);
    $display("test port_d done");
    port_e_in <= 4'hF;
    wt(3);
    rd(3'h3, 8'h08);
    master_clear_enable_cfg <= 1'b1;
    port_e_in <= 4'h7;
    wt(3);
    chk({7'h0, master_clear_input}, 8'h01);
    master_clear_enable_cfg <= 1'b0;
    port_e_in <= 4'hF;
    wr(3'h6, 8'h00);
    wr(3'h5, 8'h07);
    wt(3);
    rd(3'h3, 8'h0F);
    wr(3'h6, 8'h07);
    wr(3'h5, 8'h02);
    wt(3);
    chk({5'h0, port_e_oe}, 8'h05);
    $display("test port_e done");
    wr(3'h7, 8'h07);
    pwm_out_c <= 1'b1;
    wr(3'h2, 8'h00);
    wt(3);
    rd(3'h0, 8'h45);
    wr(3'h7, 8'h17);
    pwm_shutdown <= 1'b1;
    wt(3);
    rd(3'h0, 8'h25);
    pwm_shutdown <= 1'b0;
    wr(3'h7, 8'h00);
    $display("test pwm done");
    wr(3'h5, 8'h17);
    wr(3'h1, 8'hC3);
    chk({7'h0, host_port_mode_sel}, 8'h01);
    hst(1'b0, 1'b1);
    rd(3'h0, 8'hC3);
    rd(3'h5, 8'h57);
    hst(1'b1, 1'b1);
    rd(3'h5, 8'h17);
    ext_val <= 8'h5A;
    hst(1'b1, 1'b0);
    hst(1'b1, 1'b1);
    chk(host_write_data, 8'h5A);
    rd(3'h5, 8'h97);
    rd(3'h0, 8'h5A);
    rd(3'h5, 8'h17);
    wr(3'h7, 8'h08);
    wt(3);
    chk({7'h0, host_port_mode_sel}, 8'h00);
    $display("test host done");
    acc(1'b1, 5'h05, 8'h00);
    chk({6'h0, resp}, 8'h02);
    rd(3'h1, 8'hC3);
    $display("test refuse done");
    results;
  end
  initial
  begin
    wt(20000);
    failures++;
    results;
  end
endmodule // testbench
`default_nettype wire
